/* efc_pkg.sv */
package efc_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] EFC_ADDR_FLAGS_PRI  = 8'h00;
   localparam logic [7:0] EFC_ADDR_FLAGS_SEC  = 8'h04;
   localparam logic [7:0] EFC_ADDR_EN_PRI     = 8'h08;
   localparam logic [7:0] EFC_ADDR_EN_SEC     = 8'h0C;
   localparam logic [7:0] EFC_ADDR_STATUS     = 8'h10;
   localparam logic [7:0] EFC_ADDR_THRESHOLD  = 8'h14;
   localparam logic [7:0] EFC_ADDR_FIFO_LEVEL = 8'h18;

   // ****************************************
   // field positions
   // ****************************************
   // primary flags
   localparam int EFC_P_TX_DONE   = 0;
   localparam int EFC_P_RX_DONE   = 1;
   localparam int EFC_P_IDLE      = 2;
   localparam int EFC_P_HIGH_WARN = 3;
   localparam int EFC_P_LOW_WARN  = 4;
   localparam int EFC_P_ERROR     = 5;
   localparam int EFC_P_SOF       = 6;
   // secondary flags
   localparam int EFC_S_TIMER_A   = 0;
   localparam int EFC_S_CARD      = 5;
   localparam int EFC_S_SUMMARY   = 6;
   localparam int EFC_SET_SEL     = 7;
   localparam int EFC_STAT_IRQ    = 0;
   localparam int EFC_STAT_HIGH   = 1;
   localparam int EFC_STAT_LOW    = 2;
   localparam int EFC_THR_EXT     = 8;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] EFC_RST_FLAGS     = 8'h00;
   localparam logic [7:0] EFC_RST_EN        = 8'h00;
   localparam logic [8:0] EFC_RST_THRESHOLD = 9'h008;
   localparam logic [1:0] EFC_RST_MASK      = 2'h0;

   // primary flags register holds bits 0..6 only, bit 7 is the selector
   localparam logic [7:0] EFC_FLAG_MASK     = 8'h7F;

endpackage : efc_pkg

/* efc_event_flag_controller.sv */
// What this block does
// - two 8-bit flag registers, each with its own 8-bit enable register
// - software writes a flag register to raise or clear flags
// - each source enabled individually; only enabled ones reach the summary
// - an enabled event sets the status interrupt bit and, with pin mask bit 0 or the summary enable set, drives the pin
// - dedicated output pin signals a pending interrupt to the host
// - four timer flags set on underflow of their timer
// - timer at zero with interrupt enabled raises its flag next timer clock
// - transmit-done set when transmitter goes from data to end-of-frame
// - receive-done set at end of received data stream
// - command-idle set when a running command returns to idle
// - one threshold sets upper level from top and lower from bottom
// - high-warning set when fill count reaches upper level with extension
// - low-warning set when low-warning status becomes one
// - error flag set when the error register goes from all bits zero to any bit one
// - card-detect set when card found in low-power card detection mode
// - start-of-frame set on frame start or subcarrier while receiving
// - summary flag set while any other enabled source is set
module efc_event_flag_controller
#(
   parameter int FIFO_DEPTH = 512,
   parameter int CNT_W      = 10
)
(
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic             i_psel,
   input  wire logic             i_penable,
   input  wire logic             i_pwrite,
   input  wire logic [7:0]       i_paddr,
   input  wire logic [31:0]      i_pwdata,
   output      logic [31:0]      o_prdata,
   output      logic             o_pready,
   output      logic             o_pslverr,
   input  wire logic [3:0]       i_timer_at_zero,
   input  wire logic [3:0]       i_timer_irq_en,
   input  wire logic [3:0]       i_timer_tick,
   input  wire logic             i_tx_end_of_frame,
   input  wire logic             i_rx_stream_end,
   input  wire logic             i_command_idle,
   input  wire logic [CNT_W-1:0] i_fifo_fill,
   input  wire logic [7:0]       i_error_bits,
   input  wire logic             i_low_power_card_detection,
   input  wire logic             i_card_found,
   input  wire logic             i_rx_active,
   input  wire logic             i_sof_or_subcarrier,
   output      logic             o_irq
);
   import efc_pkg::*;

   // ****************************************
   // register state
   // ****************************************
   logic [7:0]       flags_pri_q;
   logic [7:0]       flags_sec_q;
   logic [7:0]       en_pri_q;
   logic [7:0]       en_sec_q;
   logic [8:0]       threshold_q;
   logic [1:0]       pin_mask_q;
   logic             tx_q;
   logic             idle_q;
   logic             err_q;
   logic             hi_q;
   logic             lo_q;
   logic             status_irq_q;
   logic             hi_now;
   logic             lo_now;
   logic [CNT_W-1:0] upper_lvl;
   logic [CNT_W-1:0] lower_lvl;
   logic [7:0]       set_pri;
   logic [7:0]       set_sec;
   logic             wr;
   logic             setup;
   logic             addr_known;
   logic             wr_flags_pri;
   logic             wr_flags_sec;
   logic             wr_en_pri;
   logic             wr_en_sec;
   logic             wr_threshold;
   logic             wr_pin_mask;
   logic             any_pending;

   // ****************************************
   // address decode
   // ****************************************
   // a write lands at the edge that ends the access phase
   assign wr           = i_psel & i_penable & i_pwrite;
   assign setup        = i_psel & ~i_penable;
   assign wr_flags_pri = wr & (i_paddr == EFC_ADDR_FLAGS_PRI);
   assign wr_flags_sec = wr & (i_paddr == EFC_ADDR_FLAGS_SEC);
   assign wr_en_pri    = wr & (i_paddr == EFC_ADDR_EN_PRI);
   assign wr_en_sec    = wr & (i_paddr == EFC_ADDR_EN_SEC);
   assign wr_threshold = wr & (i_paddr == EFC_ADDR_THRESHOLD);
   assign wr_pin_mask  = wr & (i_paddr == EFC_ADDR_STATUS);

   // ****************************************
   // fifo warning levels
   // ****************************************
   // one value serves both ends; the two warnings stay symmetric while extension bit 8 is clear
   assign upper_lvl = CNT_W'(FIFO_DEPTH) - CNT_W'(threshold_q);
   assign lower_lvl = CNT_W'(threshold_q[7:0]);
   assign hi_now    = i_fifo_fill >= upper_lvl;
   assign lo_now    = i_fifo_fill <= lower_lvl;

   // ****************************************
   // event detection
   // ****************************************
   always_comb
   begin
      set_pri = 8'h00;
      set_sec = 8'h00;
      set_pri[EFC_P_TX_DONE]   = i_tx_end_of_frame & ~tx_q;
      set_pri[EFC_P_RX_DONE]   = i_rx_stream_end;
      set_pri[EFC_P_IDLE]      = i_command_idle & ~idle_q;
      set_pri[EFC_P_HIGH_WARN] = hi_now & ~hi_q;
      set_pri[EFC_P_LOW_WARN]  = lo_now & ~lo_q;
      set_pri[EFC_P_ERROR]     = (|i_error_bits) & ~err_q;
      set_pri[EFC_P_SOF]       = i_sof_or_subcarrier & i_rx_active;
      // underflow: counter sits at zero and the next timer clock arrives
      set_sec[3:0] = i_timer_at_zero & i_timer_irq_en & i_timer_tick;
      set_sec[EFC_S_CARD] = i_card_found & i_low_power_card_detection;
   end

   // transmitter is quiet after reset, so the first end-of-frame is a fresh edge
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         tx_q <= 1'b0;
      end
      else
      begin
         tx_q <= i_tx_end_of_frame;
      end
   end

   // command register counts as idle after reset: no false finish on release
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         idle_q <= 1'b1;
      end
      else
      begin
         idle_q <= i_command_idle;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         err_q <= 1'b0;
      end
      else
      begin
         err_q <= |i_error_bits;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         hi_q <= 1'b0;
      end
      else
      begin
         hi_q <= hi_now;
      end
   end

   // an empty fifo already sits at the low level, so leaving reset is no new warning
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         lo_q <= 1'b1;
      end
      else
      begin
         lo_q <= lo_now;
      end
   end

   // ****************************************
   // flag registers
   // ****************************************
   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         flags_pri_q <= EFC_RST_FLAGS;
      end
      else if (wr_flags_pri)
      begin
         if (i_pwdata[EFC_SET_SEL])
            flags_pri_q <= (flags_pri_q | (i_pwdata[7:0] & EFC_FLAG_MASK)) | set_pri;
         else
            flags_pri_q <= (flags_pri_q & ~(i_pwdata[7:0] & EFC_FLAG_MASK)) | set_pri;
      end
      else
      begin
         flags_pri_q <= flags_pri_q | set_pri;
      end
   end

   // summary bit is derived, not stored, so it cannot go stale
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         flags_sec_q <= EFC_RST_FLAGS;
      end
      else if (wr_flags_sec)
      begin
         if (i_pwdata[EFC_SET_SEL])
            flags_sec_q <= (flags_sec_q | (i_pwdata[7:0] & 8'h3F)) | set_sec;
         else
            flags_sec_q <= (flags_sec_q & ~(i_pwdata[7:0] & 8'h3F)) | set_sec;
      end
      else
      begin
         flags_sec_q <= flags_sec_q | set_sec;
      end
   end

   // ****************************************
   // enables and configuration
   // ****************************************
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         en_pri_q <= EFC_RST_EN;
      end
      else if (wr_en_pri)
      begin
         en_pri_q <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         en_sec_q <= EFC_RST_EN;
      end
      else if (wr_en_sec)
      begin
         en_sec_q <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         threshold_q <= EFC_RST_THRESHOLD;
      end
      else if (wr_threshold)
      begin
         threshold_q <= i_pwdata[8:0];
      end
   end

   // only the mask bits of the status word are writable, the rest is live state
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         pin_mask_q <= EFC_RST_MASK;
      end
      else if (wr_pin_mask)
      begin
         pin_mask_q <= i_pwdata[1:0];
      end
   end

   // ****************************************
   // summary and interrupt pin
   // ****************************************
   assign any_pending = |(flags_pri_q[6:0] & en_pri_q[6:0])
                      | |(flags_sec_q[5:0] & en_sec_q[5:0]);

   // pin mask: bit 0 or the summary enable (en_sec_q bit 6) gates any pending source onto the pin; bit 1 is unused
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         status_irq_q <= 1'b0;
      end
      else
      begin
         status_irq_q <= any_pending;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_irq <= 1'b0;
      end
      else
      begin
         o_irq <= any_pending & (pin_mask_q[0] | en_sec_q[EFC_S_SUMMARY]);
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   // single-cycle access; unmapped addresses answer with an error
   always_comb
   begin
      addr_known = 1'b0;
      unique case (i_paddr)
         EFC_ADDR_FLAGS_PRI,
         EFC_ADDR_FLAGS_SEC,
         EFC_ADDR_EN_PRI,
         EFC_ADDR_EN_SEC,
         EFC_ADDR_STATUS,
         EFC_ADDR_THRESHOLD,
         EFC_ADDR_FIFO_LEVEL: addr_known = 1'b1;
         default:             addr_known = 1'b0;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_pready <= 1'b0;
      end
      else
      begin
         o_pready <= setup;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pslverr <= setup & ~addr_known;
      end
   end

   // data is taken in the setup cycle so it stands through the access phase
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_prdata <= 32'h0000_0000;
      end
      else
      begin
         o_prdata <= 32'h0000_0000;
         if (setup)
         begin
            unique case (i_paddr)
               EFC_ADDR_FLAGS_PRI:  o_prdata[7:0] <= flags_pri_q & EFC_FLAG_MASK;
               EFC_ADDR_FLAGS_SEC:  o_prdata[7:0] <= {1'b0, any_pending, flags_sec_q[5:0]};
               EFC_ADDR_EN_PRI:     o_prdata[7:0] <= en_pri_q;
               EFC_ADDR_EN_SEC:     o_prdata[7:0] <= en_sec_q;
               EFC_ADDR_STATUS:     o_prdata[4:0] <= {pin_mask_q, lo_now, hi_now, status_irq_q};
               EFC_ADDR_THRESHOLD:  o_prdata[8:0] <= threshold_q;
               EFC_ADDR_FIFO_LEVEL: o_prdata[CNT_W-1:0] <= i_fifo_fill;
               default:             o_prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : efc_event_flag_controller

/* efc_checker.sv */
module efc_checker
   import efc_pkg::*;
#(
   parameter int CNT_W = 10
)
(
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic             i_psel,
   input  wire logic             i_penable,
   input  wire logic             i_pwrite,
   input  wire logic [7:0]       i_paddr,
   input  wire logic [CNT_W-1:0] i_fifo_fill,
   input  wire logic [31:0]      o_prdata,
   input  wire logic             o_pready,
   input  wire logic             o_pslverr,
   input  wire logic             o_irq
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   logic setup;
   logic wr;
   assign setup = i_psel && !i_penable;
   assign wr    = i_psel && i_penable && i_pwrite;
   // ****
   // bus and pin relations
   // ****
   a_ready_after_setup: assert property (setup |=> o_pready)
      else $error("no ready after setup");
   a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
      else $error("ready outside access");
   a_ready_one_cycle: assert property (o_pready |=> !o_pready)
      else $error("ready held too long");
   a_err_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   a_unmapped_refused: assert property (setup && i_paddr > EFC_ADDR_FIFO_LEVEL |=> o_pslverr)
      else $error("unmapped address accepted");
   a_mapped_accepted: assert property (setup && i_paddr <= EFC_ADDR_FIFO_LEVEL
      && i_paddr[1:0] == 2'h0 |=> !o_pslverr)
      else $error("mapped address refused");
   a_fill_readback: assert property (setup && !i_pwrite
      && i_paddr == EFC_ADDR_FIFO_LEVEL |=> o_prdata == 32'($past(i_fifo_fill)))
      else $error("fifo count read wrong");
   // sticky flags: the pin can only drop after a register write
   a_irq_fall_write: assert property ($fell(o_irq)
      |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("interrupt dropped without write");
   c_irq_rise: cover property ($rose(o_irq));
   c_irq_fall: cover property ($fell(o_irq));
   c_refused: cover property (o_pslverr);
endmodule : efc_checker

bind efc_event_flag_controller efc_checker #(.CNT_W(CNT_W)) u_chk (.i_mclk, .i_rst_n,
   .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_fifo_fill, .o_prdata, .o_pready,
   .o_pslverr, .o_irq);

/* efc_host_model.sv */
module efc_host_model
(
   input  wire logic        i_mclk,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pready,
   input  wire logic        i_pslverr,
   output      logic        o_psel,
   output      logic        o_penable,
   output      logic        o_pwrite,
   output      logic [7:0]  o_paddr,
   output      logic [31:0] o_pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output bit ok);
      int n;
      @(posedge i_mclk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_mclk);
      o_penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_mclk);
         n++;
      end
      while (i_pready !== 1'b1 && n < 16);
      ok = (i_pready === 1'b1);
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // released bus must not keep showing the last request
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask : xfer
endmodule : efc_host_model

/* efc_event_flag_controller_tb_top.sv */
module efc_event_flag_controller_tb_top;
   import efc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst_n, psel, pen, pwr, pready, pslverr, irq, e;
   logic        tx, rxe, idl, sof, card, low_power_card_detection, rxa;
   logic [7:0]  paddr, err;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  tick, tz, ten;
   logic [4:0]  fill;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          ks[7] = '{0, 1, 2, 5, 6, 7, 8};
   int          xs[7] = '{1, 2, 4, 32, 64, 1, 32};
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // small fifo keeps the warning levels reachable
   efc_event_flag_controller #(.FIFO_DEPTH(16), .CNT_W(5)) dut (.i_mclk(mclk),
      .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_timer_at_zero(tz), .i_timer_irq_en(ten), .i_timer_tick(tick),
      .i_tx_end_of_frame(tx), .i_rx_stream_end(rxe), .i_command_idle(idl),
      .i_fifo_fill(fill), .i_error_bits(err), .i_low_power_card_detection(low_power_card_detection),
      .i_card_found(card), .i_rx_active(rxa), .i_sof_or_subcarrier(sof), .o_irq(irq));
   efc_host_model host (.i_mclk(mclk), .i_prdata(prdata), .i_pready(pready),
      .i_pslverr(pslverr), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
      .o_paddr(paddr), .o_pwdata(pwdata));
   // ****
   // tasks
   // ****
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task automatic cmp(input string what, input logic [31:0] x, input logic [31:0] got);
      samples_checked++;
      if (got !== x)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, x, got);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      bit ok;
      host.xfer(w, a, d, q, e, ok);
      if (!ok)
      begin
         n_fail++;
         end_of_test();
      end
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0);
      cmp("read data", x, q);
   endtask : rd
   task automatic ev(input int k);
      @(posedge mclk);
      case (k)
         0: tx <= 1'b1;
         1: rxe <= 1'b1;
         2: idl <= 1'b1;
         5: err <= 8'h10;
         6: sof <= 1'b1;
         7: tick <= 4'h1;
         default: card <= 1'b1;
      endcase
      @(posedge mclk);
      {tx, rxe, idl, sof, card, tick, err} <= '0;
   endtask : ev
   // ****
   // main sequence
   // ****
   initial
   begin
      {rst_n, tx, rxe, idl, sof, card, tick, err, fill} = '0;
      {tz, ten, low_power_card_detection, rxa} = {4'h1, 4'h1, 1'b1, 1'b1};
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(EFC_ADDR_EN_PRI, 32'(EFC_RST_EN));
      rd(EFC_ADDR_FLAGS_SEC, 32'(EFC_RST_FLAGS));
      rd(EFC_ADDR_THRESHOLD, 32'(EFC_RST_THRESHOLD));
      acc(1'b1, EFC_ADDR_EN_SEC, 32'hA5);
      rd(EFC_ADDR_EN_SEC, 32'hA5);
      acc(1'b1, EFC_ADDR_EN_SEC, 32'h0);
      acc(1'b1, EFC_ADDR_FLAGS_PRI, 32'h7F);
      acc(1'b1, EFC_ADDR_FLAGS_PRI, 32'h85);
      rd(EFC_ADDR_FLAGS_PRI, 32'h05);
      acc(1'b1, EFC_ADDR_FLAGS_PRI, 32'h01);
      rd(EFC_ADDR_FLAGS_PRI, 32'h04);
      acc(1'b1, EFC_ADDR_FLAGS_PRI, 32'h80);
      rd(EFC_ADDR_FLAGS_PRI, 32'h04);
      $display("test registers done");
      foreach (ks[i])
      begin
         acc(1'b1, EFC_ADDR_FLAGS_PRI, 32'h7F);
         acc(1'b1, EFC_ADDR_FLAGS_SEC, 32'h7F);
         ev(ks[i]);
         rd(ks[i] < 7 ? EFC_ADDR_FLAGS_PRI : EFC_ADDR_FLAGS_SEC, 32'(xs[i]));
      end
      // sources outside their qualifying condition must leave the flags alone
      {tz, ten, low_power_card_detection, rxa} <= {4'h1, 4'h0, 1'b0, 1'b0};
      acc(1'b1, EFC_ADDR_FLAGS_PRI, 32'h7F);
      acc(1'b1, EFC_ADDR_FLAGS_SEC, 32'h7F);
      ev(6);
      ev(7);
      ev(8);
      rd(EFC_ADDR_FLAGS_PRI, 32'h00);
      rd(EFC_ADDR_FLAGS_SEC, 32'h00);
      $display("test sources done");
      acc(1'b1, EFC_ADDR_FLAGS_PRI, 32'h7F);
      fill <= 5'd12;
      rd(EFC_ADDR_FIFO_LEVEL, 32'd12);
      fill <= 5'd3;
      rd(EFC_ADDR_FIFO_LEVEL, 32'd3);
      rd(EFC_ADDR_FLAGS_PRI, 32'h18);
      acc(1'b1, EFC_ADDR_EN_PRI, 32'h10);
      acc(1'b1, EFC_ADDR_STATUS, 32'h01);
      repeat (3) @(posedge mclk);
      cmp("irq", 32'h1, 32'(irq));
      rd(EFC_ADDR_FLAGS_SEC, 32'h40);
      rd(EFC_ADDR_STATUS, 32'h0D);
      acc(1'b1, EFC_ADDR_EN_PRI, 32'h01);
      repeat (3) @(posedge mclk);
      cmp("masked irq", 32'h0, 32'(irq));
      acc(1'b1, EFC_ADDR_EN_PRI, 32'h10);
      acc(1'b1, EFC_ADDR_FLAGS_PRI, 32'h10);
      repeat (3) @(posedge mclk);
      cmp("cleared irq", 32'h0, 32'(irq));
      acc(1'b0, 8'h1C, 32'h0);
      cmp("slave error", 32'(e), 32'h1);
      $display("test interrupt done");
      end_of_test();
   end
endmodule : efc_event_flag_controller_tb_top
